// >>> rtl/can_transceiver_wake_error_ctrl.sv
// Purpose: Wake-up, mode and error supervision of a high-speed CAN
//          transceiver, with a register port for the microcontroller.
// Assumes: All inputs synchronous to core_clk; an external decoder
//          supplies frame fields from the filtered bus level.
// Notes:   Bus level input is 1 while the bus is dominant.
// Overview of operation
// - Selective wake stays off after reset; only pattern wake works.
// - Reading config registers 7..15 sets their read flag in status four.
// - Any register write clears all config read flags.
// - Selective wake enable is accepted only with all flags and no error.
// - System error while selective wake is on clears the enable.
// - Transceiver stays disabled until the activate bit is set.
// - Transmit input low too long disables transmitter until cleared.
// - Bus not going dominant four times disables transmitter until cleared.
// - Bus dominant too long latches a flag; transmitter stays enabled.
// - Receive pin not following four times disables transmitter.
// - Thermal shutdown disables transmitter; receiver is never disabled.
// - Default wake behaviour after reset is pattern detection.
// - Pattern: two pulses over 2 us, gap over 2 us, within 1.0 ms.
// - Standby frame wake sets flag and pulls receive output low; stays in standby.
// - Sleep pattern wake sets flag and enters selective sleep.
// - Selective sleep frame wake goes to standby and powers the micro.
// - Frame matching ignores the remote bit; length code is never masked.
// - Counter overflow wakes only if frame reached CRC, else restarts.
// - Frame error counter clears at each silence expiry while detecting.
// - Recessive-edge ringing up to half a bit time is filtered.
// - Receive-only blocks transmitter; receiver and termination stay on.
// - Loopback routes transmit input to the receive output.
// - Selective sleep returns to sleep after bus silence.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module can_transceiver_wake_error_ctrl
  import can_wake_pkg::*;
#(
  parameter int unsigned WIN_CYC  = WAKE_WIN_CYC,
  parameter int unsigned TXTO_CYC = TXD_DOM_CYC,
  parameter int unsigned BDOM_CYC = BUS_DOM_CYC,
  parameter int unsigned SIL_CYC  = SILENCE_CYC,
  parameter int unsigned RING_CYC = HALF_BIT_CYC,
  parameter int unsigned FEC_MAX  = FEC_LIMIT
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire reg_req_s    reg_req,
  output logic      [15:0] reg_rdata,
  input  wire logic        can_transmit_input,
  output logic             can_receive_output,
  input  wire logic        rxd_pin_sense,
  input  wire logic        bus_dominant,
  input  wire logic        thermal_shutdown_1,
  input  wire logic        system_error_in,
  input  wire frame_s      frame,
  output logic             tx_dominant_drive,
  output logic             termination_on,
  output logic             frame_bus_level,
  output logic             frame_detect_on,
  output logic             mcu_wake_req
);

  typedef struct packed {
    trx_state_e             state;
    logic                   act;
    logic                   rx_only;
    logic                   loop;
    logic                   selective_wake_enable;
    logic [NCFG-1:0][15:0]  cfg;
    logic [NCFG-1:0]        rdf;
    logic                   syserr;
    logic                   fderr;
    logic                   wake_frame;
    logic                   wake_pattern;
    logic                   txd_to;
    logic                   bus_rec;
    logic                   bus_dom;
    logic                   rxd_rec;
    logic [2:0]             tx_miss;
    logic [2:0]             rx_miss;
    logic                   seen_bus;
    logic                   seen_rx;
    logic                   txd_prev;
    logic                   bus_prev;
    logic [31:0]            txd_cnt;
    logic [31:0]            dom_cnt;
    logic [31:0]            sil_cnt;
    logic [31:0]            win_cnt;
    logic [8:0]             pcnt;
    logic [1:0]             wph;
    logic [15:0]            ring_cnt;
    logic                   filt;
    logic [5:0]             fec;
    logic                   mcu_wake;
    logic [15:0]            rdata;
  } st_s;

  st_s        q;
  st_s        d;
  logic       tx_en;
  logic       pat_on;
  logic       pat_det;
  logic       fd_on;
  logic       match;
  logic       long_run;
  logic       cfg_hit;
  logic [7:0] cidx;
  logic       sil_exp;

  assign cidx    = reg_req.addr - ADDR_CFG_FIRST;
  assign cfg_hit = reg_req.addr >= ADDR_CFG_FIRST
                && reg_req.addr <= ADDR_CFG_LAST;

  // The remote bit is deliberately not compared.
  assign match = frame.done && !frame.err
      && (((frame.id ^ q.cfg[0][10:0]) & ~q.cfg[8][10:0]) == '0)
      && (frame.dlc == q.cfg[1][3:0])
      && (((frame.data ^ {q.cfg[4], q.cfg[3], q.cfg[2]})
           & ~{q.cfg[7], q.cfg[6], q.cfg[5]}) == '0);

  // Error flags disable only the driver, never the receive path.
  assign tx_en = q.state == ST_NORM && !q.rx_only && !q.txd_to
              && !q.bus_rec && !q.rxd_rec && !thermal_shutdown_1;
  assign pat_on = (q.state == ST_STBY && !q.selective_wake_enable)
               || q.state == ST_SLEEP;
  assign fd_on = (q.state == ST_STBY && q.selective_wake_enable) || q.state == ST_PN;
  assign long_run = 32'(q.pcnt) >= WAKE_PULSE_CYC;
  assign sil_exp = !bus_dominant && q.sil_cnt == SIL_CYC - 1;
  assign pat_det = pat_on && q.wph == 2'd2 && bus_dominant
                && q.bus_prev && long_run && q.win_cnt < WIN_CYC;

  always_comb begin
    d = q;
    d.mcu_wake = 1'b0;
    d.rdata = '0;

    // Register writes; hardware sets below take priority over clears.
    if (reg_req.wr) begin
      d.rdf = '0;
      case (reg_req.addr)
        ADDR_CW4: begin
          d.act = reg_req.wdata[CW4_ACT];
          d.rx_only = reg_req.wdata[CW4_RXONLY];
          d.loop = reg_req.wdata[CW4_LOOP];
        end
        ADDR_CW16: begin
          if (!reg_req.wdata[CW16_SWEN]) begin
            d.selective_wake_enable = 1'b0;
          end else if ((&q.rdf) && !q.syserr) begin
            d.selective_wake_enable = 1'b1;
          end
        end
        ADDR_SW4: begin
          if (reg_req.wdata[SW4_SYSERR]) d.syserr = 1'b0;
          if (reg_req.wdata[SW4_FDERR]) d.fderr = 1'b0;
          if (reg_req.wdata[SW4_WUF]) d.wake_frame = 1'b0;
          if (reg_req.wdata[SW4_WUP]) d.wake_pattern = 1'b0;
        end
        ADDR_ERR: begin
          if (reg_req.wdata[ERR_TXDTO]) d.txd_to = 1'b0;
          if (reg_req.wdata[ERR_BUSREC]) d.bus_rec = 1'b0;
          if (reg_req.wdata[ERR_BUSDOM]) d.bus_dom = 1'b0;
          if (reg_req.wdata[ERR_RXDREC]) d.rxd_rec = 1'b0;
        end
        default: begin
          if (cfg_hit) d.cfg[cidx[3:0]] = reg_req.wdata;
        end
      endcase
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CW4: begin
          d.rdata[CW4_ACT] = q.act;
          d.rdata[CW4_RXONLY] = q.rx_only;
          d.rdata[CW4_LOOP] = q.loop;
        end
        ADDR_CW16: d.rdata[CW16_SWEN] = q.selective_wake_enable;
        ADDR_SW4: begin
          d.rdata[SW4_RDF +: NCFG] = q.rdf;
          d.rdata[SW4_SYSERR] = q.syserr;
          d.rdata[SW4_FDERR] = q.fderr;
          d.rdata[SW4_WUF] = q.wake_frame;
          d.rdata[SW4_WUP] = q.wake_pattern;
        end
        ADDR_ERR: begin
          d.rdata[ERR_TXDTO] = q.txd_to;
          d.rdata[ERR_BUSREC] = q.bus_rec;
          d.rdata[ERR_BUSDOM] = q.bus_dom;
          d.rdata[ERR_RXDREC] = q.rxd_rec;
          d.rdata[ERR_STATE +: 2] = q.state;
        end
        default: begin
          if (cfg_hit) begin
            d.rdata = q.cfg[cidx[3:0]];
            d.rdf[cidx[3:0]] = 1'b1;
          end
        end
      endcase
    end

    if (system_error_in) d.syserr = 1'b1;

    // Transmit dominant timeout.
    d.txd_prev = can_transmit_input;
    if (can_transmit_input) begin
      d.txd_cnt = '0;
    end else if (q.txd_cnt != TXTO_CYC) begin
      d.txd_cnt = q.txd_cnt + 32'd1;
    end else begin
      d.txd_to = 1'b1;
    end

    // Bus dominant timeout only reports.
    if (!bus_dominant) begin
      d.dom_cnt = '0;
    end else if (q.dom_cnt != BDOM_CYC) begin
      d.dom_cnt = q.dom_cnt + 32'd1;
    end else begin
      d.bus_dom = 1'b1;
    end

    // Follow checks over each dominant request while driving.
    if (!can_transmit_input && q.txd_prev) begin
      d.seen_bus = bus_dominant;
      d.seen_rx = !rxd_pin_sense;
    end else if (!can_transmit_input) begin
      if (bus_dominant) d.seen_bus = 1'b1;
      if (!rxd_pin_sense) d.seen_rx = 1'b1;
    end
    if (can_transmit_input && !q.txd_prev && tx_en) begin
      if (q.seen_bus) begin
        d.tx_miss = '0;
      end else if (32'(q.tx_miss) == FAIL_LIMIT - 1) begin
        d.tx_miss = '0;
        d.bus_rec = 1'b1;
      end else begin
        d.tx_miss = q.tx_miss + 3'd1;
      end
      if (q.seen_rx) begin
        d.rx_miss = '0;
      end else if (32'(q.rx_miss) == FAIL_LIMIT - 1) begin
        d.rx_miss = '0;
        d.rxd_rec = 1'b1;
      end else begin
        d.rx_miss = q.rx_miss + 3'd1;
      end
    end

    // Ringing filter: recessive must hold past half a bit time.
    if (bus_dominant) begin
      d.filt = 1'b1;
      d.ring_cnt = '0;
    end else if (q.filt) begin
      if (32'(q.ring_cnt) >= RING_CYC) begin
        d.filt = 1'b0;
      end else begin
        d.ring_cnt = q.ring_cnt + 16'd1;
      end
    end

    // Bus silence timer.
    if (bus_dominant || sil_exp) begin
      d.sil_cnt = '0;
    end else begin
      d.sil_cnt = q.sil_cnt + 32'd1;
    end

    // Wake pattern qualification; pcnt is the current level run length.
    d.bus_prev = bus_dominant;
    if (bus_dominant != q.bus_prev) begin
      d.pcnt = '0;
    end else if (q.pcnt != '1) begin
      d.pcnt = q.pcnt + 9'd1;
    end
    if (q.wph != 2'd0) d.win_cnt = q.win_cnt + 32'd1;
    if (!pat_on || pat_det) begin
      d.wph = 2'd0;
    end else if (q.wph != 2'd0 && q.win_cnt >= WIN_CYC) begin
      d.wph = 2'd0;
    end else begin
      case (q.wph)
        2'd0: begin
          if (bus_dominant && q.bus_prev && long_run) begin
            d.wph = 2'd1;
            d.win_cnt = 32'(q.pcnt);
          end
        end
        2'd1: begin
          if (!bus_dominant && !q.bus_prev && long_run) begin
            d.wph = 2'd2;
          end else if (bus_dominant && !q.bus_prev) begin
            d.wph = 2'd0;
          end
        end
        2'd2: d.wph = 2'd2;
        default: d.wph = 2'd0;
      endcase
    end

    if (pat_det) begin
      d.wake_pattern = 1'b1;
      if (q.state == ST_SLEEP) d.state = ST_PN;
    end

    // Frame detection and frame error counting.
    if (fd_on && match) begin
      d.wake_frame = 1'b1;
      if (q.state == ST_PN) begin
        d.state = ST_STBY;
        d.mcu_wake = 1'b1;
      end
    end
    if (fd_on && frame.err) begin
      if (32'(q.fec) + 1 >= FEC_MAX) begin
        d.fec = '0;
        if (frame.reached_crc) begin
          d.fderr = 1'b1;
          d.selective_wake_enable = 1'b0;
          d.state = ST_STBY;
          d.mcu_wake = q.state == ST_PN;
        end
      end else begin
        d.fec = q.fec + 6'd1;
      end
    end
    if (fd_on && sil_exp) begin
      d.fec = '0;
      if (q.state == ST_PN && !match) d.state = ST_SLEEP;
    end

    if (d.syserr && d.selective_wake_enable) d.selective_wake_enable = 1'b0;

    // Mode control by software.
    if (reg_req.wr && reg_req.addr == ADDR_CW4
        && reg_req.wdata[CW4_SLEEP] && !reg_req.wdata[CW4_ACT]
        && q.selective_wake_enable) begin
      d.state = ST_SLEEP;
    end
    if (d.act) begin
      d.state = ST_NORM;
    end else if (d.state == ST_NORM) begin
      d.state = ST_STBY;
    end
    if (!d.selective_wake_enable && (d.state == ST_SLEEP || d.state == ST_PN)) begin
      d.state = ST_STBY;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign tx_dominant_drive = tx_en && !can_transmit_input;
  assign termination_on = q.state == ST_NORM;
  assign frame_bus_level = !q.filt;
  assign frame_detect_on = fd_on;
  assign mcu_wake_req = q.mcu_wake;

  // Standby holds the output recessive except while a wake is pending.
  always_comb begin
    if (q.loop) begin
      can_receive_output = can_transmit_input;
    end else if (q.state == ST_NORM) begin
      can_receive_output = !bus_dominant;
    end else begin
      can_receive_output = !(q.wake_frame || q.wake_pattern);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_rdf_set;
    reg_req.rd && reg_req.addr == ADDR_CFG_FIRST |=> q.rdf[0];
  endproperty
  a_rdf_set: assert property (p_rdf_set)
    else $error("read flag not set");

  property p_rdf_clr;
    reg_req.wr |=> q.rdf == '0;
  endproperty
  a_rdf_clr: assert property (p_rdf_clr)
    else $error("write left read flags");

  property p_swen_gate;
    reg_req.wr && reg_req.addr == ADDR_CW16 && !q.selective_wake_enable
      && !((&q.rdf) && !q.syserr) |=> !q.selective_wake_enable;
  endproperty
  a_swen_gate: assert property (p_swen_gate)
    else $error("enable accepted without reads");

  property p_syserr_off;
    q.syserr |-> !q.selective_wake_enable;
  endproperty
  a_syserr_off: assert property (p_syserr_off)
    else $error("enable kept with system error");

  property p_txd_to;
    !can_transmit_input && q.txd_cnt == TXTO_CYC
      |=> q.txd_to && !tx_dominant_drive;
  endproperty
  a_txd_to: assert property (p_txd_to)
    else $error("transmit timeout not latched");

  property p_bus_dom;
    q.bus_dom && tx_en |-> tx_dominant_drive == !can_transmit_input;
  endproperty
  a_bus_dom: assert property (p_bus_dom)
    else $error("dominant flag blocked driver");

  property p_tsd;
    thermal_shutdown_1 || q.rx_only |-> !tx_dominant_drive;
  endproperty
  a_tsd: assert property (p_tsd)
    else $error("driver on during shutdown or receive-only");

  property p_loop;
    q.loop |-> can_receive_output == can_transmit_input;
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback not routed");

  property p_sleep_wup;
    q.state == ST_SLEEP && pat_det && q.selective_wake_enable && !q.act && !reg_req.wr
      && !system_error_in |=> q.state == ST_PN && q.wake_pattern;
  endproperty
  a_sleep_wup: assert property (p_sleep_wup)
    else $error("sleep pattern wake missed");

  property p_pn_wuf;
    q.state == ST_PN && match && q.selective_wake_enable && !q.act && !reg_req.wr
      |=> q.state == ST_STBY && q.wake_frame && $rose(mcu_wake_req);
  endproperty
  a_pn_wuf: assert property (p_pn_wuf)
    else $error("frame wake missed");

  c_sw_on: cover property (!q.selective_wake_enable ##1 q.selective_wake_enable);
  c_pn_wake: cover property (q.state == ST_PN ##1 q.state == ST_STBY);
  c_pattern: cover property (pat_det);
  c_busrec: cover property ($rose(q.bus_rec));

endmodule

// >>> rtl/can_wake_pkg.sv
// Purpose: Shared constants and types of the CAN wake and error controller.
// Assumes: A 100 MHz core clock and 16-bit register data.
// Notes:   Timing figures are kept in their own units; counts derive here.
package can_wake_pkg;

  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned CLK_NS          = 10;
  localparam int unsigned T_WAKE_PULSE_US = 2;
  localparam int unsigned T_WAKE_WIN_US   = 1000;
  localparam int unsigned T_TXD_DOM_US    = 1000;
  localparam int unsigned T_BUS_DOM_US    = 1000;
  localparam int unsigned T_SILENCE_US    = 1000000;
  localparam int unsigned CAN_BIT_NS      = 1000;
  localparam int unsigned RING_PCT        = 50;
  localparam int unsigned FAIL_LIMIT      = 4;
  localparam int unsigned FEC_LIMIT       = 31;
  localparam int unsigned NCFG            = 9;

  localparam int unsigned WAKE_PULSE_CYC = T_WAKE_PULSE_US * CLK_MHZ;
  localparam int unsigned WAKE_WIN_CYC   = T_WAKE_WIN_US * CLK_MHZ;
  localparam int unsigned TXD_DOM_CYC    = T_TXD_DOM_US * CLK_MHZ;
  localparam int unsigned BUS_DOM_CYC    = T_BUS_DOM_US * CLK_MHZ;
  localparam int unsigned SILENCE_CYC    = T_SILENCE_US * CLK_MHZ;
  localparam int unsigned HALF_BIT_CYC   = CAN_BIT_NS * RING_PCT
                                         / (100 * CLK_NS);

  localparam logic [7:0] ADDR_CW4       = 8'h04;
  localparam logic [7:0] ADDR_CFG_FIRST = 8'h07;
  localparam logic [7:0] ADDR_CFG_LAST  = 8'h0f;
  localparam logic [7:0] ADDR_CW16      = 8'h10;
  localparam logic [7:0] ADDR_SW4       = 8'h14;
  localparam logic [7:0] ADDR_ERR       = 8'h15;

  localparam int CW4_ACT    = 0;
  localparam int CW4_RXONLY = 1;
  localparam int CW4_LOOP   = 2;
  localparam int CW4_SLEEP  = 3;
  localparam int CW16_SWEN  = 0;
  localparam int SW4_RDF    = 0;
  localparam int SW4_SYSERR = 9;
  localparam int SW4_FDERR  = 10;
  localparam int SW4_WUF    = 11;
  localparam int SW4_WUP    = 12;
  localparam int ERR_TXDTO  = 0;
  localparam int ERR_BUSREC = 1;
  localparam int ERR_BUSDOM = 2;
  localparam int ERR_RXDREC = 3;
  localparam int ERR_STATE  = 4;

  typedef enum logic [1:0] {
    ST_STBY  = 2'b00,
    ST_NORM  = 2'b01,
    ST_SLEEP = 2'b10,
    ST_PN    = 2'b11
  } trx_state_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic        done;
    logic        err;
    logic        reached_crc;
    logic        rtr;
    logic [3:0]  dlc;
    logic [10:0] id;
    logic [47:0] data;
  } frame_s;

endpackage

// >>> tb/can_bus_model.sv
// Purpose: Far side of the transceiver: the bus wire and the RXD pin.
// Assumes: Bus is dominant when the driver or another node pulls it.
// Notes:   Fault inputs let the bench break the bus or clamp the pin.
`timescale 1ns/1ns
module can_bus_model (
  input  wire logic core_clk,
  input  wire logic tx_dominant_drive,
  input  wire logic can_receive_output,
  input  wire logic slow,
  input  wire logic bus_stuck_rec,
  input  wire logic rxd_clamp,
  input  wire logic ext_dom,
  output logic      bus_dominant,
  output logic      rxd_pin_sense
);
  logic drive_q;

  // A slow bus shows the driver one cycle late, as a long cable would.
  always_ff @(posedge core_clk) begin
    drive_q <= tx_dominant_drive;
  end

  assign bus_dominant = !bus_stuck_rec
                        && ((slow ? drive_q : tx_dominant_drive) || ext_dom);
  assign rxd_pin_sense = rxd_clamp ? 1'b1 : can_receive_output;
endmodule

// >>> tb/tb_top.sv
// Purpose: Self-checking bench of the wake and error controller.
// Assumes: Shortened timeouts; configuration registers left at zero.
// Notes:   Read results are queued by the driver, checked by a monitor.
`timescale 1ns/1ns
module tb_top
  import can_wake_pkg::*;
;
  localparam int unsigned TXTO = 200;
  localparam int unsigned BDOM = 200;
  localparam int unsigned SIL  = 300;
  localparam int unsigned WIN  = 2000;

  logic        core_clk, rst_n, txd, rxo, rxs, bus_dom, tsd, sys_err;
  logic        drive, term, fbl, fdo, wake, stuck, clamp, ext, slow, rd_seen;
  logic [15:0] reg_rdata;
  reg_req_s    reg_req;
  frame_s      frame;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int          mismatches, checks_done, cycles;

  can_transceiver_wake_error_ctrl #(
    .WIN_CYC(WIN), .TXTO_CYC(TXTO), .BDOM_CYC(BDOM), .SIL_CYC(SIL),
    .RING_CYC(50), .FEC_MAX(4)
  ) can_transceiver_wake_error_ctrl_i (
    .core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .can_transmit_input(txd),
    .can_receive_output(rxo), .rxd_pin_sense(rxs),
    .bus_dominant(bus_dom), .thermal_shutdown_1(tsd),
    .system_error_in(sys_err), .frame(frame),
    .tx_dominant_drive(drive), .termination_on(term),
    .frame_bus_level(fbl), .frame_detect_on(fdo), .mcu_wake_req(wake)
  );

  can_bus_model can_bus_model_i (
    .core_clk(core_clk), .tx_dominant_drive(drive),
    .can_receive_output(rxo), .slow(slow), .bus_stuck_rec(stuck),
    .rxd_clamp(clamp), .ext_dom(ext), .bus_dominant(bus_dom),
    .rxd_pin_sense(rxs)
  );

  always #5 core_clk = ~core_clk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e, m);
    @(posedge core_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_req <= '0;
  endtask

  task automatic cfg_all();
    for (int a = 7; a <= 15; a++) rd(8'(a), 16'h0000, 16'hffff);
  endtask

  // Dominant request of three cycles, so that a slow bus still follows it.
  task automatic txp(input logic e);
    @(posedge core_clk);
    txd <= 1'b0;
    @(negedge core_clk);
    chk("tx_dominant_drive", drive, e);
    cyc(3);
    txd <= 1'b1;
    cyc(10);
  endtask

  task automatic pls(input int hi, input int lo);
    @(posedge core_clk);
    ext <= 1'b1;
    cyc(hi);
    ext <= 1'b0;
    cyc(lo);
  endtask

  task automatic pattern();
    pls($urandom_range(210, 240), $urandom_range(210, 240));
    pls($urandom_range(210, 240), 5);
  endtask

  task automatic send(input logic [3:0] dlc);
    @(posedge core_clk);
    frame <= '{done: 1'b1, err: 1'b0, reached_crc: 1'b0, rtr: 1'b1,
               dlc: dlc, id: 11'h000, data: 48'h0};
    @(posedge core_clk);
    frame <= '0;
  endtask

  // One erroneous frame, with or without a CRC field.
  task automatic bad(input logic crc);
    @(posedge core_clk);
    frame <= '{done: 1'b0, err: 1'b1, reached_crc: crc, rtr: 1'b0,
               dlc: 4'h0, id: 11'h000, data: 48'h0};
    @(posedge core_clk);
    frame <= '0;
  endtask

  always @(posedge core_clk) rd_seen <= reg_req.rd && rst_n;

  always @(negedge core_clk) begin
    logic [15:0] m;
    m = 16'h0000;
    if (rd_seen && exp_q.size() > 0) begin
      m = msk_q.pop_front();
      chk("reg_rdata", reg_rdata & m, exp_q.pop_front() & m);
    end else if (rd_seen) begin
      chk("reg_rdata_queue", 16'h0000, 16'h0001);
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 60000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    reg_req = '0;
    frame = '0;
    {txd, tsd, sys_err, stuck, clamp, ext, slow} = 7'b1000000;
    void'($urandom(32'h3807));
    cyc(8);
    rst_n <= 1'b1;
    rd(ADDR_CW16, 16'h0000, 16'hffff);
    rd(ADDR_SW4, 16'h0000, 16'hffff);
    rd(ADDR_ERR, 16'h0000, 16'hffff);
    txp(1'b0);
    for (int a = 7; a <= 14; a++) rd(8'(a), 16'h0000, 16'hffff);
    rd(ADDR_SW4, 16'h00ff, 16'h01ff);
    wr(ADDR_CW16, 16'h0001);
    rd(ADDR_CW16, 16'h0000, 16'h0001);
    rd(ADDR_SW4, 16'h0000, 16'h01ff);
    cfg_all();
    rd(ADDR_SW4, 16'h01ff, 16'h01ff);
    wr(ADDR_CW16, 16'h0001);
    rd(ADDR_CW16, 16'h0001, 16'h0001);
    rd(ADDR_SW4, 16'h0000, 16'h01ff);
    @(posedge core_clk);
    sys_err <= 1'b1;
    @(posedge core_clk);
    sys_err <= 1'b0;
    rd(ADDR_CW16, 16'h0000, 16'h0001);
    cfg_all();
    wr(ADDR_CW16, 16'h0001);
    rd(ADDR_CW16, 16'h0000, 16'h0001);
    wr(ADDR_SW4, 16'h1e00);
    wr(ADDR_CW4, 16'h0001);
    rd(ADDR_ERR, 16'h0010, 16'h0030);
    txp(1'b1);
    @(posedge core_clk);
    txd <= 1'b0;
    cyc(TXTO + 5);
    txd <= 1'b1;
    rd(ADDR_ERR, 16'h0001, 16'h0001);
    txp(1'b0);
    wr(ADDR_ERR, 16'h000f);
    slow <= 1'b1;
    txp(1'b1);
    for (int k = 0; k < 2; k++) begin
      stuck <= (k == 0);
      clamp <= (k == 1);
      repeat (4) txp(1'b1);
      txp(1'b0);
      rd(ADDR_ERR, k ? 16'h0008 : 16'h0002, k ? 16'h0008 : 16'h0002);
      stuck <= 1'b0;
      clamp <= 1'b0;
      wr(ADDR_ERR, 16'h000f);
      txp(1'b1);
    end
    pls(BDOM + 10, 5);
    rd(ADDR_ERR, 16'h0004, 16'h0004);
    txp(1'b1);
    wr(ADDR_ERR, 16'h000f);
    @(posedge core_clk);
    tsd <= 1'b1;
    ext <= 1'b1;
    txp(1'b0);
    @(negedge core_clk);
    chk("can_receive_output", rxo, 1'b0);
    @(posedge core_clk);
    tsd <= 1'b0;
    ext <= 1'b0;
    txp(1'b1);
    wr(ADDR_CW4, 16'h0003);
    @(posedge core_clk);
    ext <= 1'b1;
    txp(1'b0);
    @(negedge core_clk);
    chk("can_receive_output", rxo, 1'b0);
    chk("termination_on", term, 1'b1);
    @(posedge core_clk);
    ext <= 1'b0;
    wr(ADDR_CW4, 16'h0005);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      txd <= 1'($urandom_range(0, 1));
      @(negedge core_clk);
      chk("can_receive_output", rxo, txd);
    end
    @(posedge core_clk);
    txd <= 1'b1;
    wr(ADDR_CW4, 16'h0000);
    wr(ADDR_SW4, 16'h1e00);
    pls(150, 250);
    pls(150, 250);
    rd(ADDR_SW4, 16'h0000, 16'h1000);
    pls(250, WIN + 100);
    pls(250, 300);
    rd(ADDR_SW4, 16'h0000, 16'h1000);
    pattern();
    rd(ADDR_SW4, 16'h1000, 16'h1000);
    @(negedge core_clk);
    chk("can_receive_output", rxo, 1'b0);
    wr(ADDR_SW4, 16'h1e00);
    cfg_all();
    wr(ADDR_CW16, 16'h0001);
    wr(ADDR_CW4, 16'h0008);
    rd(ADDR_ERR, 16'h0020, 16'h0030);
    pattern();
    rd(ADDR_ERR, 16'h0030, 16'h0030);
    rd(ADDR_SW4, 16'h1000, 16'h1000);
    @(negedge core_clk);
    chk("frame_detect_on", fdo, 1'b1);
    cyc(SIL + 20);
    rd(ADDR_ERR, 16'h0020, 16'h0030);
    pattern();
    send(4'h1);
    rd(ADDR_ERR, 16'h0030, 16'h0030);
    send(4'h0);
    @(negedge core_clk);
    chk("mcu_wake_req", wake, 1'b1);
    rd(ADDR_ERR, 16'h0000, 16'h0030);
    rd(ADDR_SW4, 16'h0800, 16'h0800);
    wr(ADDR_SW4, 16'h1e00);
    send(4'h0);
    @(negedge core_clk);
    chk("mcu_wake_req", wake, 1'b0);
    chk("can_receive_output", rxo, 1'b0);
    rd(ADDR_SW4, 16'h0800, 16'h0800);
    rd(ADDR_ERR, 16'h0000, 16'h0030);
    pls(2, 2);
    @(negedge core_clk);
    chk("frame_bus_level", fbl, 1'b0);
    repeat (4) bad(1'b0);
    rd(ADDR_SW4, 16'h0000, 16'h0400);
    repeat (3) bad(1'b1);
    cyc(SIL + 20);
    @(negedge core_clk);
    chk("frame_bus_level", fbl, 1'b1);
    bad(1'b1);
    rd(ADDR_SW4, 16'h0000, 16'h0400);
    pls(2, 2);
    repeat (3) bad(1'b1);
    rd(ADDR_SW4, 16'h0400, 16'h0400);
    rd(ADDR_CW16, 16'h0000, 16'h0001);
    cyc(3);
    stop_test();
  end
endmodule
